//--- src/pcd_pkg.sv
// Package with constants, enums and carrier structs of the PCM codec digital interface
package pcd_pkg;
   // Timing: one 8 kHz frame and the steady-level limit of the receive bit clock
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int FRAME_PERIOD_US  = 125;
   localparam int STEADY_TIME_US   = 125;
   localparam int FRAME_CYCLES     = (FRAME_PERIOD_US * 1000000) / CLK_PERIOD_PS;
   localparam int STEADY_CYCLES    = (STEADY_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
   localparam int PD_FRAMES        = 3;
   localparam logic [1:0] QUIET_FRAMES   = 2'h2;
   localparam logic [1:0] LONG_MIN_EDGES = 2'h2;
   localparam logic [4:0] WORD_BITS      = 5'h08;
   localparam logic [4:0] SHORT_BASE     = 5'h01;
   localparam logic [4:0] B2_BASE        = 5'h08;
   localparam logic [4:0] POS_MAX        = 5'h1f;
   // Master clock edges per frame divided by this shift give the divide ratio to 256 kHz
   localparam int SEQ_PER_FRAME_LOG2     = 5;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_TX_WORD = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;
   localparam logic [7:0] REG_RX_WORD = 8'h0c;
   localparam logic [7:0] REG_CODES   = 8'h10;
   // Control bits and reset value
   localparam int CTRL_TX_EN   = 0;
   localparam int CTRL_IDLE    = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // Status field positions
   localparam int ST_MODE_LSB  = 0;
   localparam int ST_PWR_DN    = 2;
   localparam int ST_QUIET     = 3;
   localparam int ST_CHAN      = 4;
   localparam int ST_LAW       = 5;
   localparam int ST_RATIO_LSB = 8;
   // Companded code words: sign, chord, step
   localparam logic [7:0] MU_POS_FS   = 8'h80;
   localparam logic [7:0] MU_POS_ZERO = 8'hff;
   localparam logic [7:0] MU_NEG_ZERO = 8'h7f;
   localparam logic [7:0] MU_NEG_FS   = 8'h00;
   localparam logic [7:0] A_POS_FS    = 8'haa;
   localparam logic [7:0] A_POS_ZERO  = 8'hd5;
   localparam logic [7:0] A_NEG_ZERO  = 8'h55;
   localparam logic [7:0] A_NEG_FS    = 8'h2a;

   typedef enum logic [1:0] {MODE_LONG, MODE_SHORT, MODE_IDL, MODE_GCI} pcd_mode_e;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } pcd_wb_req_s;

   typedef struct packed {
      logic rx_frame_sync;
      logic rx_bit_clock;
      logic rx_pcm_in;
      logic tx_frame_sync;
      logic tx_bit_clock;
      logic master_clock;
      logic power_down_n;
      logic law_sel;
   } pcd_pins_s;
endpackage

//--- src/pcd_sync.sv
// Two-flop synchroniser for the asynchronous codec pins
`timescale 1ns/100ps
`default_nettype none
module pcd_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   // Only the second stage is read outside this module
   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               meta[i]   <= 1'b0;
               sync_o[i] <= 1'b0;
            end else begin
               meta[i]   <= async_i[i];
               sync_o[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- src/pcd_top.sv
// PCM codec digital interface: mode detect, receive/transmit serial, power-down, prescaler, registers
//
// Notes on behaviour
// - Receive frame sync may be asynchronous to transmit
// - ISDN modes: receive sync selects B1/B2
// - Separate modes accept 64 to 4096 kHz bit clock
// - Receive bit clock held high: interchip link mode
// - Receive bit clock held low: GCI mode
// - Separate modes use receive clocks; ISDN uses transmit
// - Power-down input low powers device down
// - Both frame syncs low with clocks: power down
// - Powered down: transmit data output high impedance
// - Transmit data quiet two frame syncs after power-up
// - Detect master clock rate, divide to 256 kHz
// - Master clock handling independent of serial mode
// - Law chosen by pin; timing law-independent
// - Mu-law zero and full-scale code words
// - A-law zero and full-scale code words
// - Long or short sync decided every frame
// - Long sync: eight falling latches, ninth rising transfer
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pcd_top #(
   parameter logic [15:0] FRAME_CYCLES  = 16'(pcd_pkg::FRAME_CYCLES),
   parameter logic [15:0] STEADY_CYCLES = 16'(pcd_pkg::STEADY_CYCLES),
   parameter logic [1:0]  PD_FRAMES     = 2'(pcd_pkg::PD_FRAMES)
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire pcd_pkg::pcd_wb_req_s wb_req_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   input  wire pcd_pkg::pcd_pins_s  pins_i,
   output logic                     tx_pcm_out_o,
   output logic                     tx_pcm_out_oe_n_o,
   output logic                     analog_hiz_o,
   output logic [7:0]               rx_word_o,
   output logic                     rx_word_valid_o,
   output logic                     seq_tick_o
);
   pcd_pkg::pcd_pins_s p;
   pcd_pkg::pcd_pins_s q;
   pcd_pkg::pcd_mode_e mode;
   logic        isdn;
   logic        chan;
   logic [15:0] steady_cnt;
   logic [1:0]  fs_edges;
   logic        long_sel;
   logic        tb_rise, tb_fall, tfs_rise, tfs_fall, rb_rise, rb_fall, mc_rise;
   logic        r_fall, r_rise, r_fs;
   logic        rx_act;
   logic [4:0]  rx_pos, rx_base;
   logic [7:0]  rx_shift;
   logic        tx_act;
   logic [4:0]  tx_pos, tx_base;
   logic [7:0]  tx_shift;
   logic        tx_allowed;
   logic        next_drive;
   logic [4:0]  tx_idx;
   logic [15:0] frame_timer;
   logic        seen_fs, seen_tb, seen_mc;
   logic [1:0]  low_frames;
   logic        powered_down;
   logic        next_powered_down;
   logic [1:0]  quiet_cnt;
   logic [9:0]  mclk_cnt;
   logic [4:0]  ratio;
   logic [4:0]  div_cnt;
   logic [1:0]  ctrl;
   logic [7:0]  tx_word;
   logic [31:0] codes;
   logic [7:0]  pos_zero;
   logic [31:0] status;
   logic [31:0] next_rdata;
   logic        wb_hit;

   pcd_sync #(
      .WIDTH ($bits(pcd_pkg::pcd_pins_s))
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (pins_i),
      .sync_o  (p)
   );

   // Previous synchronised levels for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= p;
      end
   end

   assign tb_rise  = p.tx_bit_clock & ~q.tx_bit_clock;
   assign tb_fall  = ~p.tx_bit_clock & q.tx_bit_clock;
   assign tfs_rise = p.tx_frame_sync & ~q.tx_frame_sync;
   assign tfs_fall = ~p.tx_frame_sync & q.tx_frame_sync;
   assign rb_rise  = p.rx_bit_clock & ~q.rx_bit_clock;
   assign rb_fall  = ~p.rx_bit_clock & q.rx_bit_clock;
   assign mc_rise  = p.master_clock & ~q.master_clock;

   // Steady-level watch on the receive bit clock; any bit clock from 64 kHz toggles well inside the limit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         steady_cnt <= '0;
      end else if (p.rx_bit_clock != q.rx_bit_clock) begin
         steady_cnt <= '0;
      end else if (steady_cnt != STEADY_CYCLES) begin
         steady_cnt <= steady_cnt + 16'h0001;
      end
   end

   assign isdn = (steady_cnt == STEADY_CYCLES);

   // Long versus short sync, re-decided at the end of every transmit frame sync pulse that spans a falling bit clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fs_edges <= '0;
         long_sel <= 1'b0;
      end else if (tfs_fall) begin
         if (fs_edges != 2'h0) begin
            long_sel <= (fs_edges >= pcd_pkg::LONG_MIN_EDGES);
         end
         fs_edges <= '0;
      end else if (tb_fall && p.tx_frame_sync && fs_edges != pcd_pkg::LONG_MIN_EDGES) begin
         fs_edges <= fs_edges + 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= pcd_pkg::MODE_LONG;
      end else if (isdn) begin
         mode <= p.rx_bit_clock ? pcd_pkg::MODE_IDL : pcd_pkg::MODE_GCI;
      end else begin
         mode <= long_sel ? pcd_pkg::MODE_LONG : pcd_pkg::MODE_SHORT;
      end
   end

   assign chan = isdn & p.rx_frame_sync;

   // Receive clocking source follows the mode; the receive sync needs no phase tie to the transmit one
   assign r_fall = isdn ? tb_fall : rb_fall;
   assign r_rise = isdn ? tb_rise : rb_rise;
   assign r_fs   = isdn ? 1'b0 : p.rx_frame_sync;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_act          <= 1'b0;
         rx_pos          <= '0;
         rx_base         <= '0;
         rx_shift        <= '0;
         rx_word_o       <= '0;
         rx_word_valid_o <= 1'b0;
      end else begin
         rx_word_valid_o <= 1'b0;
         if (powered_down) begin
            rx_act <= 1'b0;
         end else if (isdn && tfs_rise) begin
            rx_act  <= 1'b1;
            rx_pos  <= '0;
            rx_base <= chan ? pcd_pkg::B2_BASE : 5'h00;
         end else if (!rx_act && r_fall && r_fs) begin
            rx_act <= 1'b1;
            if (mode == pcd_pkg::MODE_LONG) begin
               rx_base  <= 5'h00;
               rx_pos   <= 5'h01;
               rx_shift <= {rx_shift[6:0], p.rx_pcm_in};
            end else begin
               rx_base <= pcd_pkg::SHORT_BASE;
               rx_pos  <= pcd_pkg::SHORT_BASE;
            end
         end else if (rx_act && r_fall && rx_pos != pcd_pkg::POS_MAX) begin
            rx_pos <= rx_pos + 5'h01;
            if (rx_pos >= rx_base && rx_pos < rx_base + pcd_pkg::WORD_BITS) begin
               rx_shift <= {rx_shift[6:0], p.rx_pcm_in};
            end
         end else if (rx_act && r_rise && rx_pos == rx_base + pcd_pkg::WORD_BITS) begin
            rx_word_o       <= rx_shift;
            rx_word_valid_o <= 1'b1;
            rx_act          <= 1'b0;
         end
      end
   end

   // Frame-period watch for sync-driven power-down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_timer <= '0;
         seen_fs     <= 1'b0;
         seen_tb     <= 1'b0;
         seen_mc     <= 1'b0;
         low_frames  <= '0;
      end else if (tfs_rise) begin
         low_frames  <= '0;
         frame_timer <= '0;
         seen_fs     <= 1'b1;
      end else if (frame_timer == FRAME_CYCLES - 16'h0001) begin
         frame_timer <= '0;
         seen_fs     <= 1'b0;
         seen_tb     <= 1'b0;
         seen_mc     <= 1'b0;
         if (!seen_fs && seen_tb && seen_mc) begin
            if (low_frames != PD_FRAMES) begin
               low_frames <= low_frames + 2'h1;
            end
         end else begin
            low_frames <= '0;
         end
      end else begin
         frame_timer <= frame_timer + 16'h0001;
         seen_fs     <= seen_fs | p.tx_frame_sync | p.rx_frame_sync;
         seen_tb     <= seen_tb | tb_rise;
         seen_mc     <= seen_mc | mc_rise;
      end
   end

   assign next_powered_down = ~p.power_down_n | (low_frames == PD_FRAMES);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         powered_down <= 1'b0;
         analog_hiz_o <= 1'b0;
      end else begin
         powered_down <= next_powered_down;
         analog_hiz_o <= next_powered_down;
      end
   end

   // Quiet period after power-up protects the shared highway from contention
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         quiet_cnt  <= '0;
         tx_allowed <= 1'b0;
      end else if (powered_down) begin
         quiet_cnt  <= '0;
         tx_allowed <= 1'b0;
      end else if (tfs_rise) begin
         tx_allowed <= (quiet_cnt == pcd_pkg::QUIET_FRAMES);
         if (quiet_cnt != pcd_pkg::QUIET_FRAMES) begin
            quiet_cnt <= quiet_cnt + 2'h1;
         end
      end
   end

   assign pos_zero = p.law_sel ? pcd_pkg::A_POS_ZERO : pcd_pkg::MU_POS_ZERO;

   // Transmit slot counter; bit timing is the same whichever law is selected
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_act   <= 1'b0;
         tx_pos   <= '0;
         tx_base  <= '0;
         tx_shift <= '0;
      end else if (tfs_rise) begin
         tx_act   <= 1'b1;
         tx_pos   <= '0;
         tx_shift <= ctrl[pcd_pkg::CTRL_IDLE] ? pos_zero : tx_word;
         if (isdn) begin
            tx_base <= chan ? pcd_pkg::B2_BASE : 5'h00;
         end else begin
            tx_base <= long_sel ? 5'h00 : pcd_pkg::SHORT_BASE;
         end
      end else if (tx_act && tb_rise) begin
         if (tx_pos == pcd_pkg::POS_MAX) begin
            tx_act <= 1'b0;
         end else begin
            tx_pos <= tx_pos + 5'h01;
         end
      end
   end

   assign tx_idx     = tx_pos - tx_base;
   // Next power state, so the driver lets go in the same cycle the device powers down
   assign next_drive = tx_act && tx_allowed && ctrl[pcd_pkg::CTRL_TX_EN] && !next_powered_down
                       && tx_pos >= tx_base
                       && (tx_pos < tx_base + pcd_pkg::WORD_BITS
                           || (mode == pcd_pkg::MODE_LONG && p.tx_frame_sync));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_pcm_out_o      <= 1'b0;
         tx_pcm_out_oe_n_o <= 1'b1;
      end else begin
         tx_pcm_out_oe_n_o <= ~next_drive;
         tx_pcm_out_o      <= next_drive & (tx_idx < pcd_pkg::WORD_BITS) & tx_shift[3'(~tx_idx[2:0])];
      end
   end

   // Prescaler: master clock edges per transmit frame set the divide ratio to the sequencing rate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mclk_cnt <= '0;
         ratio    <= 5'h01;
      end else if (tfs_rise) begin
         mclk_cnt <= '0;
         if (mclk_cnt[9:pcd_pkg::SEQ_PER_FRAME_LOG2] != 5'h00) begin
            ratio <= mclk_cnt[9:pcd_pkg::SEQ_PER_FRAME_LOG2];
         end
      end else if (mc_rise && mclk_cnt != 10'h3ff) begin
         mclk_cnt <= mclk_cnt + 10'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt    <= '0;
         seq_tick_o <= 1'b0;
      end else begin
         seq_tick_o <= 1'b0;
         if (powered_down) begin
            div_cnt <= '0;
         end else if (mc_rise) begin
            if (div_cnt + 5'h01 >= ratio) begin
               div_cnt    <= '0;
               seq_tick_o <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 5'h01;
            end
         end
      end
   end

   // Zero and full-scale code words of the selected law, readable for software
   assign codes = p.law_sel ?
      {pcd_pkg::A_NEG_FS, pcd_pkg::A_NEG_ZERO, pcd_pkg::A_POS_ZERO, pcd_pkg::A_POS_FS} :
      {pcd_pkg::MU_NEG_FS, pcd_pkg::MU_NEG_ZERO, pcd_pkg::MU_POS_ZERO, pcd_pkg::MU_POS_FS};

   always_comb begin
      status = '0;
      status[pcd_pkg::ST_MODE_LSB +: 2] = mode;
      status[pcd_pkg::ST_PWR_DN]        = powered_down;
      status[pcd_pkg::ST_QUIET]         = ~tx_allowed;
      status[pcd_pkg::ST_CHAN]          = chan;
      status[pcd_pkg::ST_LAW]           = p.law_sel;
      status[pcd_pkg::ST_RATIO_LSB +: 5] = ratio;
   end

   always_comb begin
      unique case (wb_req_i.adr)
         pcd_pkg::REG_CTRL:    next_rdata = {30'h0, ctrl};
         pcd_pkg::REG_TX_WORD: next_rdata = {24'h0, tx_word};
         pcd_pkg::REG_STATUS:  next_rdata = status;
         pcd_pkg::REG_RX_WORD: next_rdata = {24'h0, rx_word_o};
         pcd_pkg::REG_CODES:   next_rdata = codes;
         default:              next_rdata = '0;
      endcase
   end

   // Wishbone classic slave: one wait state, unmapped addresses read zero and ignore writes
   assign wb_hit = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= wb_hit ? next_rdata : '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl    <= pcd_pkg::CTRL_RESET;
         tx_word <= '0;
      end else if (wb_ack_o && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0]) begin
         if (wb_req_i.adr == pcd_pkg::REG_CTRL) begin
            ctrl <= wb_req_i.dat[1:0];
         end
         if (wb_req_i.adr == pcd_pkg::REG_TX_WORD) begin
            tx_word <= wb_req_i.dat[7:0];
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/pcd_top_assertions.sv
// Port checker for the PCM codec digital interface
`timescale 1ns/100ps
`default_nettype none
module pcd_top_assertions #(
   parameter logic [15:0] FRAME_CYCLES = 16'h00c8
) (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire pcd_pkg::pcd_wb_req_s wb_req_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire pcd_pkg::pcd_pins_s   pins_i,
   input wire logic                 tx_pcm_out_o,
   input wire logic                 tx_pcm_out_oe_n_o,
   input wire logic                 analog_hiz_o,
   input wire logic [7:0]           rx_word_o,
   input wire logic                 rx_word_valid_o,
   input wire logic                 seq_tick_o
);
   logic [15:0] up_cnt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Cycles since power-up, saturating so a long run never wraps
   always_ff @(posedge clk_i) begin
      if (rst_i || analog_hiz_o) begin
         up_cnt <= 16'h0000;
      end else if (up_cnt != 16'hffff) begin
         up_cnt <= up_cnt + 16'h0001;
      end
   end
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held too long");
   property p_ack_next;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_pd_pin;
      !pins_i.power_down_n [*6] |-> analog_hiz_o;
   endproperty
   a_pd_pin: assert property (p_pd_pin) else $error("no power-down on pin");
   property p_hiz_tx;
      analog_hiz_o |-> tx_pcm_out_oe_n_o;
   endproperty
   a_hiz_tx: assert property (p_hiz_tx) else $error("driving while down");
   property p_off_low;
      tx_pcm_out_oe_n_o |-> !tx_pcm_out_o;
   endproperty
   a_off_low: assert property (p_off_low) else $error("data while released");
   property p_quiet;
      !tx_pcm_out_oe_n_o |-> up_cnt > FRAME_CYCLES;
   endproperty
   a_quiet: assert property (p_quiet) else $error("drove too soon after power-up");
   property p_word_flag;
      $changed(rx_word_o) |-> rx_word_valid_o;
   endproperty
   a_word_flag: assert property (p_word_flag) else $error("word changed silently");
   property p_valid_once;
      rx_word_valid_o |=> !rx_word_valid_o;
   endproperty
   a_valid_once: assert property (p_valid_once) else $error("valid too long");
   property p_tick_gap;
      seq_tick_o |=> !seq_tick_o [*2];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
   c_write: cover property (wb_ack_o && wb_req_i.we);
   c_word: cover property (rx_word_valid_o);
   c_drive: cover property (!tx_pcm_out_oe_n_o);
   c_down: cover property ($rose(analog_hiz_o));
endmodule
bind pcd_top pcd_top_assertions #(.FRAME_CYCLES(FRAME_CYCLES)) pcd_top_assertions_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pins_i(pins_i), .tx_pcm_out_o(tx_pcm_out_o), .tx_pcm_out_oe_n_o(tx_pcm_out_oe_n_o),
   .analog_hiz_o(analog_hiz_o), .rx_word_o(rx_word_o), .rx_word_valid_o(rx_word_valid_o),
   .seq_tick_o(seq_tick_o));
`default_nettype wire

//--- verification/pcd_highway.sv
// Behavioural PCM highway controller: frame syncs, bit clocks, receive data
`timescale 1ns/100ps
`default_nettype none
module pcd_highway (
   input  wire logic clk_i,
   output logic      tx_frame_sync_o,
   output logic      rx_frame_sync_o,
   output logic      tx_bit_clock_o,
   output logic      rx_bit_clock_o,
   output logic      rx_pcm_in_o
);
   logic hold;
   logic hold_lvl;
   logic chan;
   initial begin
      tx_frame_sync_o = 1'b0;
      tx_bit_clock_o  = 1'b0;
      rx_pcm_in_o     = 1'b0;
      hold            = 1'b0;
      hold_lvl        = 1'b0;
      chan            = 1'b0;
   end
   // Held receive clock picks an ISDN mode; receive sync then is the channel
   assign rx_bit_clock_o  = hold ? hold_lvl : tx_bit_clock_o;
   assign rx_frame_sync_o = hold ? chan : tx_frame_sync_o;
   // Clocks scaled to the short test frame; sync and data move on the rise
   task automatic bit_slot(input logic fs, input logic d);
      tx_bit_clock_o  <= 1'b1;
      tx_frame_sync_o <= fs;
      rx_pcm_in_o     <= d;
      repeat (10) @(posedge clk_i);
      tx_bit_clock_o <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask
   // Ten slots per frame, one sync per frame period
   task automatic frame(input logic lng, input logic [7:0] w);
      if (!lng) begin
         bit_slot(1'b1, ~w[7]);
      end
      for (int i = 7; i >= 0; i--) begin
         bit_slot(lng, w[i]);
      end
      bit_slot(1'b0, ~w[0]);
      if (lng) begin
         bit_slot(1'b0, w[0]);
      end
   endtask
   // Clocks run, syncs stay low, released data keeps changing
   task automatic idle(input int n);
      repeat (n) bit_slot(1'b0, ~rx_pcm_in_o);
   endtask
   task automatic hold_rx(input logic en, input logic lvl, input logic ch);
      hold     <= en;
      hold_lvl <= lvl;
      chan     <= ch;
   endtask
endmodule
`default_nettype wire

//--- verification/pcd_top_bench.sv
// Self-checking bench for the PCM codec digital interface
`timescale 1ns/100ps
`default_nettype none
module pcd_top_bench;
   typedef struct packed {
      logic        we;
      logic [7:0]  adr;
      logic [31:0] dat;
      logic        law;
      logic [31:0] exp;
   } pcd_row_s;
   localparam pcd_row_s ROWS [8] = '{
      '{1'b0, pcd_pkg::REG_CODES, 32'h0, 1'b0, 32'h007fff80},
      '{1'b0, pcd_pkg::REG_CODES, 32'h0, 1'b1, 32'h2a55d5aa},
      '{1'b0, pcd_pkg::REG_CTRL, 32'h0, 1'b0, 32'h0},
      '{1'b1, pcd_pkg::REG_CTRL, 32'h2, 1'b0, 32'h0},
      '{1'b0, pcd_pkg::REG_CTRL, 32'h0, 1'b0, 32'h2},
      '{1'b1, pcd_pkg::REG_TX_WORD, 32'h1a5, 1'b0, 32'h0},
      '{1'b0, pcd_pkg::REG_TX_WORD, 32'h0, 1'b0, 32'ha5},
      '{1'b0, 8'h14, 32'h0, 1'b0, 32'h0}};
   logic                 clk_i;
   logic                 rst_i;
   pcd_pkg::pcd_wb_req_s wb_req;
   pcd_pkg::pcd_pins_s   pins;
   logic [31:0]          wb_dat;
   logic                 ack;
   logic                 tx_out;
   logic                 oe_n;
   logic                 hiz;
   logic [7:0]           rx_word;
   logic                 tick;
   logic                 tfs;
   logic                 rfs;
   logic                 tbc;
   logic                 rbc;
   logic                 rdat;
   logic                 pd_n;
   logic                 law;
   logic                 tbc_q;
   logic [7:0]           tx_cap;
   logic [31:0]          ticks;
   logic [31:0]          drives;
   logic [31:0]          mark;
   logic [31:0]          rd;
   logic [31:0]          words;
   logic [3:0]           wb_sel;
   logic                 rx_valid;
   int                   n_mismatch;
   int                   n_compared;
   // Master clock shares the transmit bit clock, as a board may wire it
   assign pins = {rfs, rbc, rdat, tfs, tbc, tbc, pd_n, law};
   pcd_top #(.FRAME_CYCLES(16'h00c8), .STEADY_CYCLES(16'h0096)) pcd_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(ack),
      .pins_i(pins), .tx_pcm_out_o(tx_out), .tx_pcm_out_oe_n_o(oe_n), .analog_hiz_o(hiz),
      .rx_word_o(rx_word), .rx_word_valid_o(rx_valid), .seq_tick_o(tick));
   pcd_highway pcd_highway_i (
      .clk_i(clk_i), .tx_frame_sync_o(tfs), .rx_frame_sync_o(rfs), .tx_bit_clock_o(tbc),
      .rx_bit_clock_o(rbc), .rx_pcm_in_o(rdat));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Serial words are taken on the falling bit clock, as a highway would
   always @(posedge clk_i) begin
      tbc_q <= tbc;
      if (!oe_n) begin
         drives <= drives + 32'h1;
      end
      if (tbc_q && !tbc && !oe_n) begin
         tx_cap <= {tx_cap[6:0], tx_out};
      end
      if (tick) begin
         ticks <= ticks + 32'h1;
      end
      if (rx_valid) begin
         words <= words + 32'h1;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: wb_sel, dat: dat};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = wb_dat;
      check({31'h0, ack}, 32'h1);
      wb_req <= '0;
      @(posedge clk_i);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      conclude();
   end
   initial begin
      rst_i = 1'b1;
      wb_req = '0;
      pd_n = 1'b1;
      law = 1'b0;
      tbc_q = 1'b0;
      tx_cap = 8'h00;
      ticks = 32'h0;
      drives = 32'h0;
      words = 32'h0;
      wb_sel = 4'hf;
      n_mismatch = 0;
      n_compared = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      check({29'h0, oe_n, hiz, ack}, 32'h4);
      foreach (ROWS[i]) begin
         law <= ROWS[i].law;
         repeat (4) @(posedge clk_i);
         wb(ROWS[i].we, ROWS[i].adr, ROWS[i].dat);
         if (!ROWS[i].we) check(rd, ROWS[i].exp);
      end
      // Byte lane 0 off: the write must be ignored
      wb_sel = 4'he;
      wb(1'b1, pcd_pkg::REG_CTRL, 32'h1);
      wb_sel = 4'hf;
      wb(1'b0, pcd_pkg::REG_CTRL, 32'h0);
      check(rd, 32'h2);
      pcd_highway_i.idle(10);
      // The sync form seen in one frame governs the next, so only the second frame's word is checked
      for (int k = 0; k < 2; k++) begin
         mark = words;
         repeat (2) pcd_highway_i.frame(k[0], 8'h96 ^ {8{k[0]}});
         check(words - mark, 32'h2);
         check({24'h0, rx_word}, {24'h0, 8'h96 ^ {8{k[0]}}});
         wb(1'b0, pcd_pkg::REG_STATUS, 32'h0);
         check({30'h0, rd[1:0]}, {31'h0, ~k[0]});
      end
      pd_n <= 1'b0;
      pcd_highway_i.idle(2);
      check({30'h0, hiz, oe_n}, 32'h3);
      wb(1'b1, pcd_pkg::REG_CTRL, 32'h1);
      pd_n <= 1'b1;
      mark = drives;
      repeat (2) pcd_highway_i.frame(1'b1, 8'h00);
      check(drives - mark, 32'h0);
      repeat (2) pcd_highway_i.frame(1'b1, 8'h00);
      check({24'h0, tx_cap}, 32'ha5);
      // Idle code follows the law pin with unchanged timing
      for (int k = 0; k < 2; k++) begin
         law <= k[0];
         wb(1'b1, pcd_pkg::REG_CTRL, 32'h3);
         pcd_highway_i.frame(1'b1, 8'h00);
         mark = ticks;
         pcd_highway_i.frame(1'b1, 8'h00);
         check(ticks - mark, 32'ha);
         check({24'h0, tx_cap}, k[0] ? 32'hd5 : 32'hff);
      end
      pcd_highway_i.idle(20);
      check({31'h0, hiz}, 32'h0);
      pcd_highway_i.idle(20);
      wb(1'b0, pcd_pkg::REG_STATUS, 32'h0);
      check({30'h0, hiz, rd[2]}, 32'h3);
      pcd_highway_i.frame(1'b1, 8'h00);
      check({31'h0, hiz}, 32'h0);
      pcd_highway_i.hold_rx(1'b1, 1'b1, 1'b0);
      repeat (3) pcd_highway_i.frame(1'b1, 8'h3c);
      check({24'h0, rx_word}, 32'h3c);
      wb(1'b0, pcd_pkg::REG_STATUS, 32'h0);
      check({29'h0, rd[4], rd[1:0]}, 32'h2);
      pcd_highway_i.hold_rx(1'b1, 1'b0, 1'b1);
      repeat (2) pcd_highway_i.frame(1'b1, 8'h00);
      mark = ticks;
      pcd_highway_i.frame(1'b1, 8'h00);
      check(ticks - mark, 32'ha);
      wb(1'b0, pcd_pkg::REG_STATUS, 32'h0);
      check({29'h0, rd[4], rd[1:0]}, 32'h7);
      pcd_highway_i.hold_rx(1'b0, 1'b0, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
